// ===== hdl/serial_bus_control.sv
// control register of the byte-oriented two-wire interface
// assumes engine status, timer overflow and count registers share mclk
`include "serial_bus_params.svh"
`timescale 1ns/1ns
module serial_bus_control #(
  parameter int COUNT_W = `SBC_COUNT_W
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  output logic [7:0] sfrRdData,
  input wire serial_bus_pkg::engine_status_s engine,
  input wire logic timerOverflow,
  input wire logic [COUNT_W-1:0] sclHighCount,
  input wire logic [COUNT_W-1:0] sclLowCount,
  input wire logic generalCallAccept,
  input wire logic globalIrqEnable,
  input wire logic busIrqEnable,
  output logic interfaceEnable,
  output logic irqRequest,
  output logic masterScl,
  output logic ackValid,
  output logic ackDriveLow,
  output serial_bus_pkg::bus_cmd_s busCmd
);
  initial begin
    if (COUNT_W < 2 || COUNT_W > 16) begin
      $error("COUNT_W out of range");
    end
  end

  // ************************************************************
  // control register
  // ************************************************************
  logic enable_r, enable_nxt;
  logic startRequest_r, startRequest_nxt;
  logic stopRequest_r, stopRequest_nxt;
  logic flag_r, flag_nxt;
  logic assertAck_r, assertAck_nxt;
  logic sclSource_r, sclSource_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic irq_r, irq_nxt;
  logic hit;
  logic stopDone;

  always_comb begin
    hit = sfrWr && (sfrAddr == `SBC_ADDR);
    enable_nxt = enable_r;
    startRequest_nxt = startRequest_r;
    stopRequest_nxt = stopRequest_r;
    flag_nxt = flag_r;
    assertAck_nxt = assertAck_r;
    sclSource_nxt = sclSource_r;
    if (hit) begin
      // bits 7 and 1 are dropped here
      enable_nxt = sfrWrData[`SBC_BIT_EN];
      startRequest_nxt = sfrWrData[`SBC_BIT_START];
      stopRequest_nxt = sfrWrData[`SBC_BIT_STOP];
      assertAck_nxt = sfrWrData[`SBC_BIT_ACK];
      sclSource_nxt = sfrWrData[`SBC_BIT_SRC];
      // writing one cannot raise the flag; only hardware does
      if (!sfrWrData[`SBC_BIT_FLAG]) begin
        flag_nxt = 1'b0;
      end
    end
    if (stopDone) begin
      stopRequest_nxt = 1'b0;
    end
    // a report in the clearing cycle is kept: set wins
    if (enable_r && engine.stateEntered) begin
      flag_nxt = 1'b1;
    end
    if (!enable_r) begin
      stopRequest_nxt = hit ? stopRequest_nxt : 1'b0;
    end
    rdData_nxt = 8'h00;
    rdData_nxt[`SBC_BIT_EN] = enable_nxt;
    rdData_nxt[`SBC_BIT_START] = startRequest_nxt;
    rdData_nxt[`SBC_BIT_STOP] = stopRequest_nxt;
    rdData_nxt[`SBC_BIT_FLAG] = flag_nxt;
    rdData_nxt[`SBC_BIT_ACK] = assertAck_nxt;
    rdData_nxt[`SBC_BIT_SRC] = sclSource_nxt;
    irq_nxt = flag_nxt && globalIrqEnable && busIrqEnable;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      enable_r <= 1'b0;
      startRequest_r <= 1'b0;
      stopRequest_r <= 1'b0;
      flag_r <= 1'b0;
      assertAck_r <= 1'b0;
      sclSource_r <= 1'b0;
      rdData_r <= `SBC_RESET;
      irq_r <= 1'b0;
    end else begin
      enable_r <= enable_nxt;
      startRequest_r <= startRequest_nxt;
      stopRequest_r <= stopRequest_nxt;
      flag_r <= flag_nxt;
      assertAck_r <= assertAck_nxt;
      sclSource_r <= sclSource_nxt;
      rdData_r <= rdData_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ************************************************************
  // scl generator
  // ************************************************************
  logic sclLevel_r, sclLevel_nxt;
  logic [COUNT_W-1:0] sclCount_r, sclCount_nxt;
  logic sclRun;

  always_comb begin
    sclRun = enable_r && engine.isMaster;
    sclLevel_nxt = sclLevel_r;
    sclCount_nxt = sclCount_r;
    if (!sclRun) begin
      sclLevel_nxt = 1'b1;
      sclCount_nxt = '0;
    end else if (sclSource_r) begin
      // one toggle per overflow gives half the overflow rate
      if (timerOverflow) begin
        sclLevel_nxt = !sclLevel_r;
      end
    end else begin
      // counts are taken as cycles; zero behaves as one
      if (sclCount_r + COUNT_W'(1) >= (sclLevel_r ? sclHighCount : sclLowCount)) begin
        sclLevel_nxt = !sclLevel_r;
        sclCount_nxt = '0;
      end else begin
        sclCount_nxt = sclCount_r + COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sclLevel_r <= 1'b1;
      sclCount_r <= '0;
    end else begin
      sclLevel_r <= sclLevel_nxt;
      sclCount_r <= sclCount_nxt;
    end
  end

  // ************************************************************
  // start and stop sequencing
  // ************************************************************
  serial_bus_pkg::start_state_e state_r, state_nxt;
  logic [COUNT_W:0] halfCount_r, halfCount_nxt;
  logic [COUNT_W:0] halfTarget;
  serial_bus_pkg::bus_cmd_s cmd_r, cmd_nxt;
  logic stopDone_r, stopDone_nxt;

  assign stopDone = stopDone_r;

  always_comb begin
    halfTarget = ({1'b0, sclHighCount} + {1'b0, sclLowCount}) >> 1;
    state_nxt = state_r;
    halfCount_nxt = halfCount_r;
    cmd_nxt = '0;
    stopDone_nxt = 1'b0;
    // stop is handled first so start and stop give stop then start
    if (enable_r && stopRequest_r && !stopDone_r) begin
      if (engine.isMaster) begin
        if (!cmd_r.stopPulse && state_r != serial_bus_pkg::ST_WAIT_FREE) begin
          cmd_nxt.stopPulse = 1'b1;
          state_nxt = serial_bus_pkg::ST_WAIT_FREE;
        end
        stopDone_nxt = engine.stopSeen;
      end else begin
        cmd_nxt.internalStopPulse = 1'b1;
        stopDone_nxt = 1'b1;
      end
    end
    case (state_r)
      serial_bus_pkg::ST_IDLE: begin
        if (startRequest_r && !stopRequest_r) begin
          if (engine.isMaster && engine.transferring) begin
            cmd_nxt.repStartPulse = 1'b1;
            state_nxt = serial_bus_pkg::ST_HOLD;
          end else if (!engine.busBusy) begin
            cmd_nxt.startPulse = 1'b1;
            state_nxt = serial_bus_pkg::ST_HOLD;
          end else begin
            state_nxt = serial_bus_pkg::ST_WAIT_FREE;
          end
        end
      end
      serial_bus_pkg::ST_WAIT_FREE: begin
        halfCount_nxt = '0;
        if (!engine.busBusy && !stopRequest_r) begin
          state_nxt = startRequest_r ? serial_bus_pkg::ST_HALF : serial_bus_pkg::ST_IDLE;
        end
      end
      serial_bus_pkg::ST_HALF: begin
        // timer source: half a bit is one overflow
        if (sclSource_r ? timerOverflow : (halfCount_r + 1'b1 >= halfTarget)) begin
          cmd_nxt.startPulse = startRequest_r && !engine.busBusy;
          state_nxt = startRequest_r && !engine.busBusy ? serial_bus_pkg::ST_HOLD
                                                         : serial_bus_pkg::ST_WAIT_FREE;
        end else begin
          halfCount_nxt = halfCount_r + 1'b1;
        end
        if (!startRequest_r) begin
          state_nxt = serial_bus_pkg::ST_IDLE;
          cmd_nxt.startPulse = 1'b0;
        end
      end
      serial_bus_pkg::ST_HOLD: begin
        // one start per request; software lowers the bit to re-arm
        if (!startRequest_r) begin
          state_nxt = serial_bus_pkg::ST_IDLE;
        end
      end
      default: state_nxt = serial_bus_pkg::ST_IDLE;
    endcase
    if (!enable_r) begin
      state_nxt = serial_bus_pkg::ST_IDLE;
      cmd_nxt = '0;
      stopDone_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= serial_bus_pkg::ST_IDLE;
      halfCount_r <= '0;
      cmd_r <= '0;
      stopDone_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      halfCount_r <= halfCount_nxt;
      cmd_r <= cmd_nxt;
      stopDone_r <= stopDone_nxt;
    end
  end

  // ************************************************************
  // acknowledge decision
  // ************************************************************
  logic ackValid_r, ackValid_nxt;
  logic ackLow_r, ackLow_nxt;

  always_comb begin
    ackValid_nxt = enable_r && engine.ackSlot;
    ackLow_nxt = ackLow_r;
    if (enable_r && engine.ackSlot) begin
      // general call counts only while accepted; all else follows the bit
      ackLow_nxt = assertAck_r && (engine.ackKind != serial_bus_pkg::ACK_GEN_CALL
                                   || generalCallAccept);
    end
    if (!enable_r) begin
      ackLow_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ackValid_r <= 1'b0;
      ackLow_r <= 1'b0;
    end else begin
      ackValid_r <= ackValid_nxt;
      ackLow_r <= ackLow_nxt;
    end
  end

  assign sfrRdData = rdData_r;
  assign interfaceEnable = enable_r;
  assign irqRequest = irq_r;
  assign masterScl = sclLevel_r;
  assign ackValid = ackValid_r;
  assign ackDriveLow = ackLow_r;
  assign busCmd = cmd_r;
endmodule : serial_bus_control

// ===== hdl/serial_bus_params.svh
// constants for the two-wire control register logic
// assumes a byte-wide special function register bus on one clock
`ifndef SERIAL_BUS_PARAMS_SVH
`define SERIAL_BUS_PARAMS_SVH
`define SBC_ADDR 8'hd8
`define SBC_BIT_EN 6
`define SBC_BIT_START 5
`define SBC_BIT_STOP 4
`define SBC_BIT_FLAG 3
`define SBC_BIT_ACK 2
`define SBC_BIT_SRC 0
`define SBC_RESET 8'h00
`define SBC_COUNT_W 8
`endif

// ===== hdl/serial_bus_pkg.sv
// types shared by the control register logic and its neighbours
// assumes the engine reports with same-clock pulses
package serial_bus_pkg;
  typedef enum logic [1:0] {
    ACK_OWN_ADDR = 2'b00,
    ACK_GEN_CALL = 2'b01,
    ACK_MASTER_RX = 2'b10,
    ACK_SLAVE_RX = 2'b11
  } ack_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_FREE = 2'b01,
    ST_HALF = 2'b10,
    ST_HOLD = 2'b11
  } start_state_e;

  typedef struct packed {
    logic isMaster;
    logic transferring;
    logic busBusy;
    logic stopSeen;
    logic stateEntered;
    logic ackSlot;
    ack_kind_e ackKind;
  } engine_status_s;

  typedef struct packed {
    logic startPulse;
    logic repStartPulse;
    logic stopPulse;
    logic internalStopPulse;
  } bus_cmd_s;
endpackage : serial_bus_pkg

// ===== tb/serial_bus_control_props.sv
// concurrent checks on the two-wire control register ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module serial_bus_control_props #(
  parameter int COUNT_W = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic [7:0] sfrRdData,
  input wire serial_bus_pkg::engine_status_s engine,
  input wire logic [COUNT_W-1:0] sclHighCount,
  input wire logic generalCallAccept,
  input wire logic globalIrqEnable,
  input wire logic busIrqEnable,
  input wire logic irqRequest,
  input wire logic masterScl,
  input wire logic ackValid,
  input wire logic ackDriveLow,
  input wire serial_bus_pkg::bus_cmd_s busCmd
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence start_seen_s;
    $rose(sfrRdData[5]) && !engine.busBusy && !engine.isMaster && !sfrRdData[4] && sfrRdData[6];
  endsequence
  sequence master_stop_s;
    busCmd.stopPulse ##[1:6] engine.stopSeen ##[1:2] !sfrRdData[4];
  endsequence
  ack_answer_a: assert property (engine.ackSlot && sfrRdData[6] |=> ackValid &&
    ackDriveLow == ($past(sfrRdData[2]) && ($past(engine.ackKind) != serial_bus_pkg::ACK_GEN_CALL
    || $past(generalCallAccept)))) else $error("ack answer wrong");
  flag_set_a: assert property (engine.stateEntered && sfrRdData[6] |=> sfrRdData[3])
    else $error("flag not set");
  flag_hold_a: assert property (sfrRdData[3] && !(sfrWr && sfrAddr == 8'hd8 &&
    !sfrWrData[3]) |=> sfrRdData[3]) else $error("flag lost");
  irq_gate_a: assert property (irqRequest == (sfrRdData[3] &&
    $past(globalIrqEnable) && $past(busIrqEnable))) else $error("irq wrong");
  // the pulse is decided one edge earlier, so a same-edge clear of the bit is legal
  start_gate_a: assert property (busCmd.startPulse || busCmd.repStartPulse |->
    $past(sfrRdData[5])) else $error("start without request");
  start_free_a: assert property (start_seen_s |-> ##1 busCmd.startPulse)
    else $error("no start on free bus");
  stop_master_a: assert property ($rose(sfrRdData[4]) && engine.isMaster |=>
    master_stop_s) else $error("master stop wrong");
  scl_high_a: assert property ($rose(masterScl) && !sfrRdData[0] &&
    sclHighCount == 3 && engine.isMaster |-> (masterScl [*3] ##1 !masterScl)
    or (1'b1 ##[1:3] !engine.isMaster)) else $error("scl high length");
endmodule : serial_bus_control_props
bind serial_bus_control serial_bus_control_props #(.COUNT_W(COUNT_W)) props_inst (
  .mclk(mclk), .reset(reset), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr),
  .sfrRdData(sfrRdData), .engine(engine), .sclHighCount(sclHighCount),
  .generalCallAccept(generalCallAccept), .globalIrqEnable(globalIrqEnable),
  .busIrqEnable(busIrqEnable), .irqRequest(irqRequest), .masterScl(masterScl),
  .ackValid(ackValid), .ackDriveLow(ackDriveLow), .busCmd(busCmd));

// ===== tb/bus_side_model.sv
// stand-in for the protocol engine and the wires beyond it
// assumes command pulses from the control block on the same clock
`timescale 1ns/1ns
module bus_side_model (
  input wire logic mclk,
  input wire logic reset,
  input wire serial_bus_pkg::bus_cmd_s busCmd,
  input wire logic otherBusy,
  input wire logic stateReq,
  input wire logic ackReq,
  input wire logic [1:0] kind,
  output serial_bus_pkg::engine_status_s engine
);
  logic master;
  logic [1:0] stopDly;
  // ****************
  // engine state
  // ****************
  // a sent stop shows on the wire two cycles later, not at once
  always_ff @(posedge mclk) begin
    if (reset) begin
      master <= 1'b0;
      stopDly <= 2'h0;
    end else begin
      stopDly <= {stopDly[0], busCmd.stopPulse};
      if (busCmd.startPulse || busCmd.repStartPulse) master <= 1'b1;
      else if (stopDly[1] || busCmd.internalStopPulse) master <= 1'b0;
    end
  end
  assign engine = '{master, master, master | otherBusy, stopDly[1], stateReq, ackReq,
    serial_bus_pkg::ack_kind_e'(kind)};
endmodule : bus_side_model

// ===== tb/serial_bus_control_test.sv
// self-checking bench for the two-wire control register
// assumes bus_side_model stands in for the engine and the wires
`timescale 1ns/1ns
module serial_bus_control_test;
  logic mclk = 1'b0, reset = 1'b1, sfrWr = 1'b0, stateReq = 1'b0, ackReq = 1'b0;
  logic generalCallAccept = 1'b0, globalIrqEnable = 1'b0, busIrqEnable = 1'b0, otherBusy = 1'b0;
  logic [1:0] kind = 2'h0;
  logic timerOverflow = 1'b0;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData, d;
  logic interfaceEnable, irqRequest, masterScl, ackValid, ackDriveLow;
  serial_bus_pkg::engine_status_s engine;
  serial_bus_pkg::bus_cmd_s busCmd;
  int err_count = 0, total_checks = 0, regModel = 0, n, i;
  serial_bus_control serial_bus_control_inst (.mclk(mclk), .reset(reset), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRdData(sfrRdData), .engine(engine),
    .timerOverflow(timerOverflow), .sclHighCount(8'h03), .sclLowCount(8'h02),
    .generalCallAccept(generalCallAccept), .globalIrqEnable(globalIrqEnable),
    .busIrqEnable(busIrqEnable), .interfaceEnable(interfaceEnable), .irqRequest(irqRequest),
    .masterScl(masterScl), .ackValid(ackValid), .ackDriveLow(ackDriveLow), .busCmd(busCmd));
  bus_side_model bus_side_model_inst (.mclk(mclk), .reset(reset), .busCmd(busCmd),
    .otherBusy(otherBusy), .stateReq(stateReq), .ackReq(ackReq), .kind(kind), .engine(engine));
  initial forever #25 mclk = ~mclk;
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    sfrAddr <= a;
    sfrWrData <= v;
    sfrWr <= 1'b1;
    @(posedge mclk);
    sfrWr <= 1'b0;
    #1;
    if (a == 8'hd8) regModel = (v & 8'h75) | (regModel & v & 8'h08);
  endtask : wr
  task automatic same();
    tick();
    chk(sfrRdData, regModel[7:0]);
  endtask : same
  // a missing pulse must not hang the run
  task automatic await(input int b);
    for (n = 0; n < 40 && busCmd[b] !== 1'b1; n++) tick();
    if (n == 40) begin
      err_count++;
      report_and_stop();
    end
  endtask : await
  // ****************
  // main sequence
  // ****************
  initial begin
    d = 8'($urandom(32'h27d9));
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    tick();
    chk({sfrRdData[7:1], masterScl}, 8'h01);
    chk({7'h00, interfaceEnable}, 8'h00);
    for (i = 0; i < 12; i++) begin
      d = 8'($urandom());
      wr((i % 4 == 3) ? 8'hd9 : 8'hd8, d & 8'hcf);
      same();
    end
    for (i = 0; i < 4; i++) begin
      wr(8'hd8, 8'h40);
      @(posedge mclk);
      {globalIrqEnable, busIrqEnable} <= 2'(i);
      stateReq <= 1'b1;
      @(posedge mclk);
      stateReq <= 1'b0;
      regModel = regModel | 8'h08;
      wr(8'hd8, 8'h48);
      same();
      chk({7'h00, irqRequest}, {7'h00, i == 3});
    end
    for (i = 0; i < 8; i++) begin
      generalCallAccept <= 1'($urandom());
      wr(8'hd8, {5'h08, i[2], 2'h0});
      kind <= 2'(i);
      ackReq <= 1'b1;
      @(posedge mclk);
      ackReq <= 1'b0;
      #1;
      chk({6'h00, ackValid, ackDriveLow},
        {6'h00, 1'b1, i[2] && (i[1:0] != 2'd1 || generalCallAccept)});
    end
    wr(8'hd8, 8'h60);
    await(3);
    repeat (20) tick();
    wr(8'hd8, 8'h40);
    wr(8'hd8, 8'h60);
    await(2);
    wr(8'hd8, 8'h40);
    wr(8'hd8, 8'h70);
    await(1);
    await(3);
    regModel = 8'h60;
    same();
    wr(8'hd8, 8'h50);
    await(1);
    repeat (6) tick();
    regModel = 8'h40;
    same();
    otherBusy <= 1'b1;
    wr(8'hd8, 8'h50);
    await(0);
    repeat (3) tick();
    regModel = 8'h40;
    same();
    wr(8'hd8, 8'h60);
    repeat (8) begin
      tick();
      chk({4'h0, busCmd}, 8'h00);
    end
    otherBusy <= 1'b0;
    await(3);
    chk({7'h00, n >= (3 + 2) / 2}, 8'h01);
    chk({7'h00, interfaceEnable}, 8'h01);
    // timer source: scl only moves on an overflow, one toggle each
    wr(8'hd8, 8'h61);
    d[0] = masterScl;
    repeat (2) begin
      repeat (3) tick();
      chk({7'h00, masterScl}, {7'h00, d[0]});
      @(posedge mclk);
      timerOverflow <= 1'b1;
      @(posedge mclk);
      timerOverflow <= 1'b0;
      #1;
      d[0] = !d[0];
      chk({7'h00, masterScl}, {7'h00, d[0]});
    end
    report_and_stop();
  end
endmodule : serial_bus_control_test
